// ==== ramp_map.svh ====
// Field widths, reset values and timing counts of the frequency ramp generator
`ifndef RAMP_MAP_SVH
`define RAMP_MAP_SVH
`define RAMP_INC_W        30
`define RAMP_LEN_W        16
`define RAMP_NUM_W        34
`define RAMP_NUM_RESET    34'h000000000
`define RAMP_LEN_RESET    16'h0000
`define RAMP_CAL_CYCLES   16'h0010
`define RAMP_CAL_CNT_W    16
`endif

// ==== ramp_pkg.sv ====
// Types shared by the frequency ramp generator
package ramp_pkg;
  `include "ramp_map.svh"
  typedef logic signed [`RAMP_NUM_W-1:0] num_t;
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_CAL  = 4'b0010,
    ST_RAMP = 4'b0100,
    ST_DONE = 4'b1000
  } ramp_state_e;
endpackage

// ==== step_sync.sv ====
// Three-stage synchroniser with rising edge detect for the step pins
`timescale 1ns/1ps
module step_sync (
  input  wire logic ref_clk,
  input  wire logic rst,
  input  wire logic clk_en,
  input  wire logic pin,
  output logic      level,
  output logic      rise
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
  } sync_s;
  sync_s q;
  sync_s d;

  always_comb begin
    d    = q;
    d.s1 = pin;
    d.s2 = q.s1;
    d.s3 = q.s2;
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else if (clk_en) begin
      q <= d;
    end
  end

  // Rise flagged while second stage is high and third stage still low
  assign level = q.s3;
  assign rise  = q.s2 & ~q.s3;
endmodule

// ==== ramp_gen.sv ====
// Frequency ramp generator: automatic two-segment and manual pin ramping
`timescale 1ns/1ps
`include "ramp_map.svh"
// Summary of operation
// - No ramping at all unless ramp enable is one.
// - Mode 0 ramps on phase-detector clock; mode 1 on step clock rises.
// - Each ramp clock adds the segment 30-bit increment to numerator.
// - Each segment lasts its length field, up to 65535 cycles.
// - Recalibrate when numerator moved by threshold since last calibration.
// - With segment-start recalibration set, recalibrate at each segment start.
// - Controller sets denominator all ones; increments scale as 2^24.
// - Numerator clamped between signed low and high limits.
// - Step clock rising edges are synchronised before stepping.
// - Step edges during calibration are discarded.
// - Manual step adds segment0 increment if direction low, else segment1.
// - Automatic mode runs up to two linear segments unaided.
// - Automatic ramping starts when calibration trigger written as one.
module ramp_gen
  import ramp_pkg::*;
#(
  parameter int INC_W = `RAMP_INC_W,
  parameter int LEN_W = `RAMP_LEN_W,
  parameter int NUM_W = `RAMP_NUM_W,
  parameter logic [`RAMP_CAL_CNT_W-1:0] CAL_CYCLES = `RAMP_CAL_CYCLES
) (
  input  wire logic             ref_clk,
  input  wire logic             rst,
  input  wire logic             clk_en,
  input  wire logic             ramp_enable,
  input  wire logic             manual_mode,
  input  wire logic             calibration_trigger,
  input  wire logic             segment_start_recal,
  input  wire logic [INC_W-1:0] segment0_increment,
  input  wire logic [INC_W-1:0] segment1_increment,
  input  wire logic [LEN_W-1:0] segment0_length,
  input  wire logic [LEN_W-1:0] segment1_length,
  input  wire logic [NUM_W-1:0] recal_distance_threshold,
  input  wire logic [NUM_W-1:0] limit_low,
  input  wire logic [NUM_W-1:0] limit_high,
  input  wire logic [NUM_W-1:0] start_numerator,
  input  wire logic             step_clock_pin,
  input  wire logic             step_direction_pin,
  output logic      [NUM_W-1:0] numerator,
  output logic                  calibrating,
  output logic                  ramp_active,
  output logic                  active_segment,
  output logic                  step_dropped
);
  typedef struct packed {
    ramp_state_e               st;
    logic signed [NUM_W-1:0]   num;
    logic signed [NUM_W-1:0]   cal_num;
    logic [LEN_W-1:0]          len_cnt;
    logic [`RAMP_CAL_CNT_W-1:0] cal_cnt;
    logic                      seg;
    logic                      trig_prev;
    logic                      dropped;
  } ramp_s;
  ramp_s q;
  ramp_s d;

  logic step_rise;

  step_sync u_step_sync (
    .ref_clk (ref_clk),
    .rst     (rst),
    .clk_en  (clk_en),
    .pin     (step_clock_pin),
    .level   (),
    .rise    (step_rise)
  );

  // Direction is sampled only at a step; controller keeps it stable then
  logic dir_s3;

  step_sync u_dir_sync (
    .ref_clk (ref_clk),
    .rst     (rst),
    .clk_en  (clk_en),
    .pin     (step_direction_pin),
    .level   (dir_s3),
    .rise    ()
  );

  logic signed [NUM_W-1:0] inc_ext;
  logic signed [NUM_W-1:0] sum;
  logic signed [NUM_W-1:0] clamped;
  logic signed [NUM_W-1:0] moved;
  logic [NUM_W-1:0]        moved_abs;
  logic                    trig_rise;
  logic                    seg_end;
  logic [INC_W-1:0]        inc_sel;
  logic                    thr_hit;

  always_comb begin
    // Manual picks by direction, automatic by active segment
    if (manual_mode) begin
      inc_sel = dir_s3 ? segment1_increment : segment0_increment;
    end else begin
      inc_sel = q.seg ? segment1_increment : segment0_increment;
    end
    // Numerator kept in 2^24 denominator units, so no rescale needed
    inc_ext = NUM_W'(signed'(inc_sel));
    sum     = q.num + inc_ext;
    if (sum > signed'(limit_high)) begin
      clamped = signed'(limit_high);
    end else if (sum < signed'(limit_low)) begin
      clamped = signed'(limit_low);
    end else begin
      clamped = sum;
    end
    moved     = clamped - q.cal_num;
    moved_abs = moved[NUM_W-1] ? NUM_W'(-moved) : NUM_W'(moved);
    thr_hit   = (recal_distance_threshold != '0) &&
                (moved_abs >= recal_distance_threshold);
    trig_rise = calibration_trigger & ~q.trig_prev;
    seg_end   = (q.len_cnt == '0);
  end

  always_comb begin
    d           = q;
    d.trig_prev = calibration_trigger;
    d.dropped   = 1'b0;
    if (!ramp_enable) begin
      d.st = ST_IDLE;
    end else begin
      unique case (q.st)
        ST_IDLE: begin
          if (manual_mode) begin
            d.st = ST_RAMP;
          end else if (trig_rise) begin
            d.num     = signed'(start_numerator);
            d.cal_num = signed'(start_numerator);
            d.seg     = 1'b0;
            d.len_cnt = segment0_length;
            d.cal_cnt = CAL_CYCLES;
            d.st      = ST_CAL;
          end
        end
        ST_CAL: begin
          if (manual_mode && step_rise) begin
            d.dropped = 1'b1;
          end
          if (q.cal_cnt <= 1) begin
            d.cal_num = q.num;
            d.st      = ST_RAMP;
          end else begin
            d.cal_cnt = q.cal_cnt - 1'b1;
          end
        end
        ST_RAMP: begin
          if (manual_mode) begin
            if (step_rise) begin
              d.num = clamped;
              if (thr_hit || segment_start_recal) begin
                d.cal_cnt = CAL_CYCLES;
                d.st      = ST_CAL;
              end
            end
          end else if (seg_end) begin
            // Second segment ends the automatic waveform
            if (q.seg) begin
              d.st = ST_DONE;
            end else begin
              d.seg     = 1'b1;
              d.len_cnt = segment1_length;
              if (segment_start_recal) begin
                d.cal_cnt = CAL_CYCLES;
                d.st      = ST_CAL;
              end
            end
          end else begin
            d.num     = clamped;
            d.len_cnt = q.len_cnt - 1'b1;
            if (thr_hit) begin
              d.cal_cnt = CAL_CYCLES;
              d.st      = ST_CAL;
            end
          end
        end
        ST_DONE: begin
          if (manual_mode || trig_rise) begin
            d.st = ST_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      q           <= '0;
      q.st        <= ST_IDLE;
      q.num       <= `RAMP_NUM_RESET;
      q.cal_num   <= `RAMP_NUM_RESET;
      q.len_cnt   <= `RAMP_LEN_RESET;
    end else if (clk_en) begin
      q <= d;
    end
  end

  assign numerator      = q.num;
  // One-hot state bits, so these come straight from the flops
  assign calibrating    = q.st[1];
  assign ramp_active    = q.st[2];
  assign active_segment = q.seg;
  assign step_dropped   = q.dropped;

  // Calibration held over two cycles
  sequence s_cal_two;
    calibrating ##1 calibrating;
  endsequence

  AST_DISABLED_IDLE: assert property (
    @(posedge ref_clk) disable iff (rst)
    (clk_en && !ramp_enable) |=> q.st == ST_IDLE)
    else $error("Ramp state left idle while disabled");

  AST_NO_STEP_IN_CAL: assert property (
    @(posedge ref_clk) disable iff (rst)
    (clk_en && q.st == ST_CAL && ramp_enable) |=> $stable(q.num))
    else $error("Numerator moved during calibration");

  AST_DROP_FLAG: assert property (
    @(posedge ref_clk) disable iff (rst)
    (clk_en && ramp_enable && manual_mode && q.st == ST_CAL && step_rise)
      |=> step_dropped)
    else $error("Step during calibration not flagged");

  AST_LIMITS: assert property (
    @(posedge ref_clk) disable iff (rst)
    (q.st == ST_RAMP && !manual_mode && clk_en && ramp_enable && !seg_end
     && signed'(limit_low) <= signed'(limit_high))
      |=> (q.num <= signed'(limit_high)) && (q.num >= signed'(limit_low)))
    else $error("Numerator beyond limits");

  AST_AUTO_STEP: assert property (
    @(posedge ref_clk) disable iff (rst)
    (clk_en && ramp_enable && !manual_mode && q.st == ST_RAMP && !seg_end)
      |=> q.num == $past(clamped))
    else $error("Automatic step not applied");

  AST_MANUAL_STEP: assert property (
    @(posedge ref_clk) disable iff (rst)
    (clk_en && ramp_enable && manual_mode && q.st == ST_RAMP && step_rise)
      |=> q.num == $past(clamped))
    else $error("Manual step not applied");

  AST_NO_IDLE_STEP: assert property (
    @(posedge ref_clk) disable iff (rst)
    (clk_en && ramp_enable && manual_mode && q.st == ST_RAMP && !step_rise)
      |=> $stable(q.num))
    else $error("Numerator moved without a step");

  AST_SEG_RECAL: assert property (
    @(posedge ref_clk) disable iff (rst)
    (clk_en && ramp_enable && !manual_mode && q.st == ST_RAMP && seg_end
     && !q.seg && segment_start_recal) |=> calibrating)
    else $error("No recalibration at segment start");

  AST_THRESH: assert property (
    @(posedge ref_clk) disable iff (rst)
    (clk_en && ramp_enable && !manual_mode && q.st == ST_RAMP && !seg_end
     && thr_hit) |=> s_cal_two)
    else $error("Threshold did not force recalibration");

  AST_TRIGGER: assert property (
    @(posedge ref_clk) disable iff (rst)
    (clk_en && ramp_enable && !manual_mode && q.st == ST_IDLE && trig_rise)
      |=> calibrating && !active_segment)
    else $error("Trigger did not start ramp");

  AST_AUTO_END: assert property (
    @(posedge ref_clk) disable iff (rst)
    (clk_en && ramp_enable && !manual_mode && q.st == ST_RAMP && seg_end
     && q.seg) |=> q.st == ST_DONE)
    else $error("Automatic ramp did not end after second segment");
endmodule

// ==== step_ctrl.sv ====
// Behavioural controller that drives the manual step pins
`timescale 1ns/1ps
module step_ctrl (
  input  wire logic ref_clk,
  output logic      step_clock_pin,
  output logic      step_direction_pin
);
  // Denominator held all ones, lock-detect delay zero
  initial begin
    step_clock_pin = 1'b0;
    step_direction_pin = 1'b0;
  end

  // Half period in ref_clk cycles; 250 gives the fastest legal rate
  // Callers never pass less, or the pin would toggle too fast
  task automatic step(input logic dir, input int half);
    @(posedge ref_clk);
    step_direction_pin <= dir;
    repeat (half) @(posedge ref_clk);
    step_clock_pin <= 1'b1;
    repeat (half) @(posedge ref_clk);
    step_clock_pin <= 1'b0;
  endtask
endmodule

// ==== tb_top.sv ====
// Self-checking bench for the frequency ramp generator
`timescale 1ns/1ps
module tb_top;
  import ramp_pkg::*;
  typedef struct {
    num_t        start;
    logic [29:0] i0;
    logic [15:0] l0;
    logic [29:0] i1;
    logic [15:0] l1;
    num_t        lo;
    num_t        hi;
    num_t        thr;
    logic        rc;
    num_t        exp;
    int          cmin;
    int          cmax;
  } case_s;
  localparam num_t WLO = 34'h200000000;
  localparam num_t WHI = 34'h1FFFFFFFF;
  // Calibration outlasts one legal step period, so a step can land in it
  localparam logic [15:0] CAL_N = 16'h0300;
  // 125 MHz phase-detector clock, no reference divide
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic        clk_en = 1'b1;
  logic        ramp_enable = 1'b0;
  logic        manual_mode = 1'b0;
  logic        calibration_trigger = 1'b0;
  logic        segment_start_recal = 1'b0;
  logic [29:0] segment0_increment = 30'h0;
  logic [29:0] segment1_increment = 30'h0;
  logic [15:0] segment0_length = 16'h0;
  logic [15:0] segment1_length = 16'h0;
  logic [33:0] recal_distance_threshold = 34'h0;
  logic [33:0] limit_low = WLO;
  logic [33:0] limit_high = WHI;
  logic [33:0] start_numerator = 34'h100;
  logic        step_clock_pin;
  logic        step_direction_pin;
  logic [33:0] numerator;
  logic        calibrating;
  logic        ramp_active;
  logic        active_segment;
  logic        step_dropped;
  logic        cal_q = 1'b0;
  int          cal_n = 0;
  int          drop_n = 0;
  int          drop0 = 0;
  int          n_mismatch = 0;
  int          samples_checked = 0;
  case_s       tbl [5];

  always #4 ref_clk = ~ref_clk;

  ramp_gen #(.CAL_CYCLES(CAL_N)) i_ramp_gen (.ref_clk, .rst, .clk_en,
    .ramp_enable, .manual_mode,
    .calibration_trigger, .segment_start_recal, .segment0_increment,
    .segment1_increment, .segment0_length, .segment1_length,
    .recal_distance_threshold, .limit_low, .limit_high, .start_numerator,
    .step_clock_pin, .step_direction_pin, .numerator, .calibrating,
    .ramp_active, .active_segment, .step_dropped);

  step_ctrl i_step_ctrl (.ref_clk, .step_clock_pin, .step_direction_pin);

  // Calibration starts and dropped steps, seen at settled edges
  always @(posedge ref_clk) begin
    cal_q <= calibrating;
    if (calibrating === 1'b1 && cal_q !== 1'b1) cal_n++;
    if (step_dropped === 1'b1) drop_n++;
  end

  task automatic check(input logic [33:0] got, input logic [33:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic complete_run();
    $display("checks=%0d mismatches=%0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Disable first, so every case starts from idle
  task automatic run_auto(input case_s c);
    int k;
    int cal0;
    int nc;
    @(posedge ref_clk);
    ramp_enable <= 1'b0;
    calibration_trigger <= 1'b0;
    segment_start_recal <= c.rc;
    segment0_increment <= c.i0;
    segment1_increment <= c.i1;
    segment0_length <= c.l0;
    segment1_length <= c.l1;
    limit_low <= c.lo;
    limit_high <= c.hi;
    recal_distance_threshold <= c.thr;
    start_numerator <= c.start;
    @(posedge ref_clk);
    ramp_enable <= 1'b1;
    @(posedge ref_clk);
    calibration_trigger <= 1'b1;
    cal0 = cal_n;
    k = 0;
    while (ramp_active !== 1'b1 && k < 1000) begin
      @(posedge ref_clk);
      k++;
    end
    while ((ramp_active | calibrating) !== 1'b0 && k < 4000) begin
      @(posedge ref_clk);
      k++;
    end
    nc = cal_n - cal0;
    check(numerator, c.exp);
    check({33'h0, nc >= c.cmin && nc <= c.cmax}, 34'h1);
    check({33'h0, active_segment}, 34'h1);
    check({33'h0, k < 4000}, 34'h1);
  endtask

  initial begin
    tbl[0] = '{34'h100, 30'h5, 16'hA, 30'h3FFFFFFD, 16'h6, WLO, WHI,
      34'h0, 1'b0, 34'h120, 1, 1};
    tbl[1] = '{34'h100, 30'h5, 16'hA, 30'h3FFFFFFD, 16'h6, WLO, WHI,
      34'h0, 1'b1, 34'h120, 2, 3};
    tbl[2] = '{34'h100, 30'h5, 16'hA, 30'h0, 16'h0, WLO, 34'h110,
      34'h0, 1'b0, 34'h110, 1, 1};
    tbl[3] = '{34'h10, 30'h3FFFFFFD, 16'hA, 30'h0, 16'h0, 34'h3FFFFFFF8,
      WHI, 34'h0, 1'b0, 34'h3FFFFFFF8, 1, 1};
    tbl[4] = '{34'h100, 30'h5, 16'hA, 30'h0, 16'h0, WLO, WHI,
      34'h14, 1'b0, 34'h132, 2, 4};
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    check(numerator, 34'h0);
    check({30'h0, calibrating, ramp_active, active_segment,
      step_dropped}, 34'h0);
    calibration_trigger <= 1'b1;
    repeat (30) @(posedge ref_clk);
    check(numerator, 34'h0);
    check(34'(cal_n), 34'h0);
    for (int i = 0; i < 5; i++) run_auto(tbl[i]);
    @(posedge ref_clk);
    ramp_enable <= 1'b0;
    manual_mode <= 1'b1;
    segment_start_recal <= 1'b0;
    recal_distance_threshold <= 34'h0;
    segment1_increment <= 30'h3FFFFFFD;
    repeat (2) @(posedge ref_clk);
    ramp_enable <= 1'b1;
    repeat (4) @(posedge ref_clk);
    i_step_ctrl.step(1'b0, 250);
    check(numerator, 34'h137);
    i_step_ctrl.step(1'b1, 250);
    check(numerator, 34'h134);
    segment_start_recal <= 1'b1;
    drop0 = drop_n;
    i_step_ctrl.step(1'b0, 250);
    i_step_ctrl.step(1'b0, 250);
    check({33'h0, calibrating}, 34'h1);
    repeat (40) @(posedge ref_clk);
    check(numerator, 34'h139);
    check({33'h0, drop_n == drop0 + 1}, 34'h1);
    complete_run();
  end

  // Cases above take about 8300 cycles
  initial begin
    repeat (20000) @(posedge ref_clk);
    n_mismatch++;
    complete_run();
  end
endmodule
